// file: design/alarm_mask_pkg.sv
// alarm mask constants: table numbers, offsets, field positions, reset values
// assumes the memory-access engine presents byte offsets of the upper memory
package alarm_mask_pkg;

  // ------------------------------------------------------------
  // upper memory tables
  // ------------------------------------------------------------
  localparam logic [7:0] TABLE_PRIMARY = 8'h01;
  localparam logic [7:0] TABLE_ALTERNATE = 8'h05;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_GROUP3_MASK = 8'hF8;
  localparam logic [7:0] OFS_GROUP3_RSVD = 8'hF9;
  localparam logic [7:0] OFS_GROUP1_MASK = 8'hFA;
  localparam logic [7:0] OFS_GROUP1_RSVD = 8'hFB;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] GROUP3_MASK_RESET = 8'h00;
  localparam logic [7:0] GROUP1_MASK_RESET = 8'h00;
  localparam logic [7:0] RESERVED_READ = 8'h00;

  // ------------------------------------------------------------
  // group-3 field positions
  // ------------------------------------------------------------
  localparam int G3_TEMPERATURE_HI = 7;
  localparam int G3_TEMPERATURE_LO = 6;
  localparam int G3_SUPPLY_HI = 5;
  localparam int G3_SUPPLY_LO = 4;
  localparam int G3_BIAS_HI = 3;
  localparam int G3_BIAS_LO = 2;
  localparam int G3_POWER_HI = 1;
  localparam int G3_POWER_LO = 0;

  // ------------------------------------------------------------
  // group-1 field positions and implemented bits
  // ------------------------------------------------------------
  localparam int G1_HIGH_BIAS = 3;
  localparam int G1_TX_POWER_HI = 1;
  localparam int G1_TX_POWER_LO = 0;
  localparam logic [7:0] GROUP1_USED = 8'h0B;

  // number of transmitter addresses
  localparam int NUM_TX = 2;

endpackage : alarm_mask_pkg

// file: design/alarm_enable_masks.sv
// alarm enable masks for a dual-transmitter controller
// assumes a two-wire memory-access engine on SYS_CLK decoding table,
// offset and transmitter address, and monitor flags on the same clock
// outputs are registered, so flag and mask changes show one edge later
//
// Summary of operation
// - fault interrupt ORs enabled group-3 alarms
// - group-3 mask bits align with status
// - bits 7,6 enable temperature high/low
// - bits 5,4 enable supply high/low
// - bits 3,2 bias monitor per transmitter
// - bits 1,0 power monitor per transmitter
// - bits 7:4 shared, 3:0 per transmitter
// - group-1 mask separate per transmitter
// - laser fault when enabled group-1 alarm
// - group-1 mask bits align with status
// - group-1 bit 3 enables high-bias trip
// - group-1 bits 1,0 enable power trips
// - group-1 bits 7:4 and 2 ignored
// - mode bit picks table 1 or 5
// - read needs level two or granted one
// - write needs level two or read-write one
// - bytes after each mask are reserved
// - shadow-write block stops nonvolatile update
`timescale 1ns/1ps

module alarm_enable_masks
  import alarm_mask_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic ACC_WR,
  input wire logic ACC_RD,
  input wire logic ACC_TX2,
  input wire logic [7:0] ACC_TABLE,
  input wire logic [7:0] ACC_OFFSET,
  input wire logic [7:0] ACC_WDATA,
  input wire logic FIRST_LEVEL_PASSWORD,
  input wire logic SECOND_LEVEL_PASSWORD,
  input wire logic TABLE_C_READWRITE_GRANT,
  input wire logic TABLE_C_READONLY_GRANT,
  input wire logic MASK_IN_TABLE5,
  input wire logic SHADOW_EEPROM_WRITE_BLOCK,
  input wire logic [7:0] ALARM_GROUP3_STATUS_ONE,
  input wire logic [7:0] ALARM_GROUP3_STATUS_TWO,
  input wire logic [7:0] ALARM_GROUP1_STATUS_ONE,
  input wire logic [7:0] ALARM_GROUP1_STATUS_TWO,
  output logic TRANSMITTER_FAULT_INTERRUPT,
  output logic [1:0] LASER_SHUTDOWN_FAULT_SIGNAL,
  output logic [7:0] ACC_RDATA,
  output logic ACC_RVALID,
  output logic ACC_HIT,
  output logic NV_WRITE,
  output logic NV_TX2,
  output logic [7:0] NV_OFFSET,
  output logic [7:0] NV_DATA
);

  // ------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------
  logic [7:0] table_sel;
  logic in_table;
  logic at_g3;
  logic at_g1;
  logic at_rsvd;
  logic read_ok;
  logic write_ok;
  logic wr_g3;
  logic wr_g1;
  logic at_mask;
  logic at_block;
  logic acc_any;
  logic rd_hit;
  logic rd_grant;
  logic nv_req;
  logic [7:0] wr_byte;

  assign table_sel = MASK_IN_TABLE5 ? TABLE_ALTERNATE : TABLE_PRIMARY;
  assign in_table = (ACC_TABLE == table_sel);
  assign at_g3 = in_table && (ACC_OFFSET == OFS_GROUP3_MASK);
  assign at_g1 = in_table && (ACC_OFFSET == OFS_GROUP1_MASK);
  assign at_rsvd = in_table && ((ACC_OFFSET == OFS_GROUP3_RSVD) || (ACC_OFFSET == OFS_GROUP1_RSVD));

  assign read_ok = SECOND_LEVEL_PASSWORD
                   || (FIRST_LEVEL_PASSWORD && (TABLE_C_READWRITE_GRANT || TABLE_C_READONLY_GRANT));
  assign write_ok = SECOND_LEVEL_PASSWORD || (FIRST_LEVEL_PASSWORD && TABLE_C_READWRITE_GRANT);

  assign wr_g3 = ACC_WR && write_ok && at_g3;
  assign wr_g1 = ACC_WR && write_ok && at_g1;

  assign at_mask = at_g3 || at_g1;
  assign at_block = at_mask || at_rsvd;
  assign acc_any = ACC_RD || ACC_WR;
  assign rd_hit = ACC_RD && at_block;
  assign rd_grant = rd_hit && read_ok && at_mask;
  assign nv_req = (wr_g3 || wr_g1) && !SHADOW_EEPROM_WRITE_BLOCK;
  assign wr_byte = at_g1 ? (ACC_WDATA & GROUP1_USED) : ACC_WDATA;

  // ------------------------------------------------------------
  // shadow mask storage
  // ------------------------------------------------------------
  logic [7:4] g3_common_q;
  logic [3:0] g3_own_q [NUM_TX];
  logic [7:0] g1_q [NUM_TX];
  logic [NUM_TX-1:0] g3_any;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      g3_common_q <= GROUP3_MASK_RESET[7:4];
    end else if (wr_g3) begin
      g3_common_q <= ACC_WDATA[7:4];
    end
  end

  // ------------------------------------------------------------
  // per-transmitter masks and faults
  // ------------------------------------------------------------
  genvar t;
  generate
    for (t = 0; t < NUM_TX; t++) begin : g_tx
      logic sel;
      logic [7:0] g3_view;
      logic [7:0] g3_flags;
      logic [7:0] g1_flags;
      logic g3_hit;
      logic g1_hit;
      logic fault_q;

      assign sel = (ACC_TX2 == (t == 1));

      always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
          g3_own_q[t] <= GROUP3_MASK_RESET[3:0];
        end else if (wr_g3 && sel) begin
          g3_own_q[t] <= ACC_WDATA[3:0];
        end
      end

      always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
          g1_q[t] <= GROUP1_MASK_RESET & GROUP1_USED;
        end else if (wr_g1 && sel) begin
          g1_q[t] <= ACC_WDATA & GROUP1_USED;
        end
      end

      // ----------------------------------------------------------
      // group-3 interrupt sources
      // ----------------------------------------------------------
      // mask bit aligns with flag
      assign g3_view = {g3_common_q, g3_own_q[t]};
      assign g3_flags = (t == 0) ? ALARM_GROUP3_STATUS_ONE : ALARM_GROUP3_STATUS_TWO;
      assign g1_flags = (t == 0) ? ALARM_GROUP1_STATUS_ONE : ALARM_GROUP1_STATUS_TWO;

      assign g3_hit = (g3_view[G3_TEMPERATURE_HI] && g3_flags[G3_TEMPERATURE_HI])
                      || (g3_view[G3_TEMPERATURE_LO] && g3_flags[G3_TEMPERATURE_LO])
                      || (g3_view[G3_SUPPLY_HI] && g3_flags[G3_SUPPLY_HI])
                      || (g3_view[G3_SUPPLY_LO] && g3_flags[G3_SUPPLY_LO])
                      || (g3_view[G3_BIAS_HI] && g3_flags[G3_BIAS_HI])
                      || (g3_view[G3_BIAS_LO] && g3_flags[G3_BIAS_LO])
                      || (g3_view[G3_POWER_HI] && g3_flags[G3_POWER_HI])
                      || (g3_view[G3_POWER_LO] && g3_flags[G3_POWER_LO]);
      assign g3_any[t] = g3_hit;

      // ----------------------------------------------------------
      // group-1 laser fault sources
      // ----------------------------------------------------------
      // high-bias and power trip sources
      assign g1_hit = (g1_q[t][G1_HIGH_BIAS] && g1_flags[G1_HIGH_BIAS])
                      || (g1_q[t][G1_TX_POWER_HI] && g1_flags[G1_TX_POWER_HI])
                      || (g1_q[t][G1_TX_POWER_LO] && g1_flags[G1_TX_POWER_LO]);

      always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
          fault_q <= 1'b0;
        end else begin
          fault_q <= g1_hit;
        end
      end
      assign LASER_SHUTDOWN_FAULT_SIGNAL[t] = fault_q;
    end
  endgenerate

  // ------------------------------------------------------------
  // fault interrupt
  // ------------------------------------------------------------
  logic int_q;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      int_q <= 1'b0;
    end else begin
      int_q <= |g3_any;
    end
  end
  assign TRANSMITTER_FAULT_INTERRUPT = int_q;

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic hit_q;
  logic [7:0] rsel_d;

  always_comb begin
    rsel_d = RESERVED_READ;
    if (at_g3) begin
      rsel_d = ACC_TX2 ? {g3_common_q, g3_own_q[1]} : {g3_common_q, g3_own_q[0]};
    end else if (at_g1) begin
      rsel_d = ACC_TX2 ? g1_q[1] : g1_q[0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_hit;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= acc_any && at_block;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= 8'h00;
    end else if (rd_grant) begin
      rdata_q <= rsel_d;
    end else if (rd_hit) begin
      rdata_q <= RESERVED_READ;
    end
  end
  assign ACC_RDATA = rdata_q;
  assign ACC_RVALID = rvalid_q;
  assign ACC_HIT = hit_q;

  // ------------------------------------------------------------
  // nonvolatile update
  // ------------------------------------------------------------
  logic nv_wr_q;
  logic nv_tx2_q;
  logic [7:0] nv_ofs_q;
  logic [7:0] nv_data_q;

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      nv_wr_q <= 1'b0;
    end else begin
      nv_wr_q <= nv_req;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      nv_tx2_q <= 1'b0;
      nv_ofs_q <= 8'h00;
      nv_data_q <= 8'h00;
    end else if (nv_req) begin
      nv_tx2_q <= ACC_TX2;
      nv_ofs_q <= ACC_OFFSET;
      nv_data_q <= wr_byte;
    end
  end
  assign NV_WRITE = nv_wr_q;
  assign NV_TX2 = nv_tx2_q;
  assign NV_OFFSET = nv_ofs_q;
  assign NV_DATA = nv_data_q;

endmodule : alarm_enable_masks

// file: dv/alarm_mask_chk_sva.sv
// checker for the alarm mask block: access answers, nv requests, outputs
// assumes it is bound to alarm_enable_masks and sees only its ports
`timescale 1ns/1ps
module alarm_mask_chk
  import alarm_mask_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic ACC_WR,
  input wire logic ACC_RD,
  input wire logic [7:0] ACC_TABLE,
  input wire logic [7:0] ACC_OFFSET,
  input wire logic [7:0] ACC_WDATA,
  input wire logic FIRST_LEVEL_PASSWORD,
  input wire logic SECOND_LEVEL_PASSWORD,
  input wire logic TABLE_C_READWRITE_GRANT,
  input wire logic TABLE_C_READONLY_GRANT,
  input wire logic MASK_IN_TABLE5,
  input wire logic SHADOW_EEPROM_WRITE_BLOCK,
  input wire logic [7:0] ALARM_GROUP3_STATUS_ONE,
  input wire logic [7:0] ALARM_GROUP3_STATUS_TWO,
  input wire logic [7:0] ALARM_GROUP1_STATUS_ONE,
  input wire logic TRANSMITTER_FAULT_INTERRUPT,
  input wire logic [1:0] LASER_SHUTDOWN_FAULT_SIGNAL,
  input wire logic [7:0] ACC_RDATA,
  input wire logic ACC_RVALID,
  input wire logic ACC_HIT,
  input wire logic NV_WRITE,
  input wire logic [7:0] NV_DATA
);
  wire sel = ACC_TABLE == (MASK_IN_TABLE5 ? TABLE_ALTERNATE : TABLE_PRIMARY) && ACC_OFFSET[7:2] == 6'h3E;
  wire rd_ok = SECOND_LEVEL_PASSWORD | FIRST_LEVEL_PASSWORD & (TABLE_C_READWRITE_GRANT | TABLE_C_READONLY_GRANT);
  wire wr_ok = SECOND_LEVEL_PASSWORD | FIRST_LEVEL_PASSWORD & TABLE_C_READWRITE_GRANT;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_sel_hit: assert property ((ACC_RD | ACC_WR) && sel |=> ACC_HIT)
    else $error("selected access gave no hit");
  a_unsel_quiet: assert property ((ACC_RD | ACC_WR) && !sel |=> !ACC_HIT && !ACC_RVALID)
    else $error("unselected access answered");
  a_read_denied: assert property (ACC_RD && sel && !rd_ok |=> ACC_RVALID && ACC_RDATA == 8'h00)
    else $error("denied read returned data");
  a_rsvd_zero: assert property (ACC_RD && sel && ACC_OFFSET[0] |=> ACC_RDATA == RESERVED_READ)
    else $error("reserved byte read nonzero");
  a_write_denied: assert property (ACC_WR && !wr_ok |=> !NV_WRITE)
    else $error("denied write reached nv");
  a_nv_block: assert property (ACC_WR && SHADOW_EEPROM_WRITE_BLOCK |=> !NV_WRITE)
    else $error("blocked write reached nv");
  a_nv_program: assert property (ACC_WR && sel && ACC_OFFSET == OFS_GROUP3_MASK && wr_ok
    && !SHADOW_EEPROM_WRITE_BLOCK |=> NV_WRITE && NV_DATA == $past(ACC_WDATA))
    else $error("granted write not programmed");
  a_fault_idle: assert property (ALARM_GROUP3_STATUS_ONE == 8'h00
    && ALARM_GROUP3_STATUS_TWO == 8'h00 |=> !TRANSMITTER_FAULT_INTERRUPT)
    else $error("interrupt without any flag");
  a_laser_rsvd: assert property ((ALARM_GROUP1_STATUS_ONE & GROUP1_USED) == 8'h00
    |=> !LASER_SHUTDOWN_FAULT_SIGNAL[0])
    else $error("laser fault from reserved bits");
endmodule // alarm_mask_chk
bind alarm_enable_masks alarm_mask_chk alarm_mask_chk_i (.*);

// file: dv/host_model.sv
// host access engine model: one byte read or write per call
// assumes answers arrive one SYS_CLK edge after the strobe
`timescale 1ns/1ps
module host_model (
  input wire logic SYS_CLK,
  output logic ACC_WR,
  output logic ACC_RD,
  output logic ACC_TX2,
  output logic [7:0] ACC_TABLE,
  output logic [7:0] ACC_OFFSET,
  output logic [7:0] ACC_WDATA
);
  initial begin
    ACC_WR = 1'b0;
    ACC_RD = 1'b0;
    ACC_TX2 = 1'b0;
    ACC_TABLE = 8'h00;
    ACC_OFFSET = 8'h00;
    ACC_WDATA = 8'h00;
  end
  task automatic xfer(input logic wr, input logic tx, input logic [7:0] tbl, input logic [7:0] ofs,
                      input logic [7:0] d);
    @(posedge SYS_CLK);
    #1;
    ACC_WR = wr;
    ACC_RD = !wr;
    ACC_TX2 = tx;
    ACC_TABLE = tbl;
    ACC_OFFSET = ofs;
    ACC_WDATA = d;
    @(posedge SYS_CLK);
    #1;
    ACC_WR = 1'b0;
    ACC_RD = 1'b0;
    ACC_WDATA = ~d;
  endtask
endmodule // host_model

// file: dv/tb_top.sv
// self-checking bench for the alarm mask block
// assumes host_model drives the access port
`timescale 1ns/1ps
module tb_top;
  import alarm_mask_pkg::*;
  logic SYS_CLK = 1'b0;
  logic NRST = 1'b0;
  logic FIRST_LEVEL_PASSWORD = 1'b0, SECOND_LEVEL_PASSWORD = 1'b1, TABLE_C_READWRITE_GRANT = 1'b0;
  logic TABLE_C_READONLY_GRANT = 1'b0, MASK_IN_TABLE5 = 1'b0, SHADOW_EEPROM_WRITE_BLOCK = 1'b0;
  logic [7:0] ALARM_GROUP3_STATUS_ONE = 8'h00, ALARM_GROUP3_STATUS_TWO = 8'h00;
  logic [7:0] ALARM_GROUP1_STATUS_ONE = 8'h00, ALARM_GROUP1_STATUS_TWO = 8'h00;
  logic ACC_WR, ACC_RD, ACC_TX2, TRANSMITTER_FAULT_INTERRUPT, ACC_RVALID, ACC_HIT, NV_WRITE, NV_TX2;
  logic [7:0] ACC_TABLE, ACC_OFFSET, ACC_WDATA, ACC_RDATA, NV_OFFSET, NV_DATA;
  logic [1:0] LASER_SHUTDOWN_FAULT_SIGNAL;
  int fail_count = 0;
  int n_compared = 0;
  alarm_enable_masks alarm_enable_masks_i (.*);
  host_model host_model_i (.*);
  initial begin
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic tx, input logic [7:0] ofs, input logic [7:0] d);
    host_model_i.xfer(1'b1, tx, MASK_IN_TABLE5 ? TABLE_ALTERNATE : TABLE_PRIMARY, ofs, d);
  endtask
  task automatic rd(input logic tx, input logic [7:0] ofs, input logic [7:0] exp);
    host_model_i.xfer(1'b0, tx, MASK_IN_TABLE5 ? TABLE_ALTERNATE : TABLE_PRIMARY, ofs, 8'h00);
    chk("read valid", {7'h00, ACC_RVALID}, 8'h01);
    chk("read data", ACC_RDATA, exp);
  endtask
  task automatic f3(input logic [7:0] a, input logic [7:0] b, input logic exp);
    ALARM_GROUP3_STATUS_ONE = a;
    ALARM_GROUP3_STATUS_TWO = b;
    @(posedge SYS_CLK);
    #1;
    chk("fault interrupt", {7'h00, TRANSMITTER_FAULT_INTERRUPT}, {7'h00, exp});
  endtask
  task automatic t_layout;
    rd(1'b0, OFS_GROUP3_MASK, GROUP3_MASK_RESET);
    rd(1'b1, OFS_GROUP1_MASK, GROUP1_MASK_RESET);
    wr(1'b0, OFS_GROUP3_RSVD, 8'hFF);
    rd(1'b0, OFS_GROUP3_RSVD, RESERVED_READ);
    wr(1'b0, OFS_GROUP3_MASK, 8'hA5);
    rd(1'b1, OFS_GROUP3_MASK, 8'hA0);
    wr(1'b1, OFS_GROUP3_MASK, 8'h5C);
    rd(1'b0, OFS_GROUP3_MASK, 8'h55);
    rd(1'b1, OFS_GROUP3_MASK, 8'h5C);
    wr(1'b0, OFS_GROUP1_MASK, 8'hFF);
    rd(1'b0, OFS_GROUP1_MASK, GROUP1_USED);
    rd(1'b1, OFS_GROUP1_MASK, 8'h00);
    $display("layout test done");
  endtask
  task automatic t_irq;
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      wr(1'b0, OFS_GROUP3_MASK, m);
      wr(1'b1, OFS_GROUP3_MASK, m & 8'hF0);
      f3(m, 8'h00, 1'b1);
      f3(~m, 8'h00, 1'b0);
      f3(8'h00, m, i >= 4);
      wr(1'b1, OFS_GROUP3_MASK, m);
      f3(8'h00, m, 1'b1);
    end
    f3(8'h00, 8'h00, 1'b0);
    $display("interrupt test done");
  endtask
  task automatic t_laser;
    wr(1'b1, OFS_GROUP1_MASK, 8'hF6);
    for (int i = 0; i < 8; i++) begin
      ALARM_GROUP1_STATUS_ONE = 8'h01 << i;
      ALARM_GROUP1_STATUS_TWO = 8'h01 << i;
      @(posedge SYS_CLK);
      #1;
      chk("laser fault", {6'h00, LASER_SHUTDOWN_FAULT_SIGNAL}, {6'h00, (i == 1), GROUP1_USED[i]});
    end
    ALARM_GROUP1_STATUS_ONE = 8'h00;
    ALARM_GROUP1_STATUS_TWO = 8'h00;
    $display("laser test done");
  endtask
  task automatic t_access;
    SECOND_LEVEL_PASSWORD = 1'b0;
    FIRST_LEVEL_PASSWORD = 1'b1;
    TABLE_C_READONLY_GRANT = 1'b1;
    wr(1'b0, OFS_GROUP3_MASK, 8'h11);
    rd(1'b0, OFS_GROUP3_MASK, 8'h80);
    TABLE_C_READONLY_GRANT = 1'b0;
    rd(1'b0, OFS_GROUP3_MASK, 8'h00);
    TABLE_C_READWRITE_GRANT = 1'b1;
    wr(1'b0, OFS_GROUP3_MASK, 8'h33);
    rd(1'b0, OFS_GROUP3_MASK, 8'h33);
    SHADOW_EEPROM_WRITE_BLOCK = 1'b1;
    wr(1'b0, OFS_GROUP3_MASK, 8'h44);
    chk("nv write blocked", {7'h00, NV_WRITE}, 8'h00);
    rd(1'b0, OFS_GROUP3_MASK, 8'h44);
    SHADOW_EEPROM_WRITE_BLOCK = 1'b0;
    wr(1'b0, OFS_GROUP3_MASK, 8'h44);
    chk("nv write", {7'h00, NV_WRITE}, 8'h01);
    chk("nv data", NV_DATA, 8'h44);
    chk("nv offset", NV_OFFSET, OFS_GROUP3_MASK);
    chk("nv tx", {7'h00, NV_TX2}, 8'h00);
    wr(1'b1, OFS_GROUP1_MASK, 8'hFF);
    chk("nv g1 tx", {7'h00, NV_TX2}, 8'h01);
    chk("nv g1 offset", NV_OFFSET, OFS_GROUP1_MASK);
    chk("nv g1 data", NV_DATA, GROUP1_USED);
    MASK_IN_TABLE5 = 1'b1;
    host_model_i.xfer(1'b0, 1'b0, TABLE_PRIMARY, OFS_GROUP3_MASK, 8'h00);
    chk("other table hit", {6'h00, ACC_HIT, ACC_RVALID}, 8'h00);
    rd(1'b0, OFS_GROUP3_MASK, 8'h44);
    $display("access test done");
  endtask
  task automatic t_reset;
    NRST = 1'b0;
    @(posedge SYS_CLK);
    #1;
    chk("reset read data", ACC_RDATA, 8'h00);
    NRST = 1'b1;
    rd(1'b1, OFS_GROUP1_MASK, GROUP1_MASK_RESET);
    rd(1'b0, OFS_GROUP3_MASK, GROUP3_MASK_RESET);
    $display("reset test done");
  endtask
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge SYS_CLK);
    #1;
    NRST = 1'b1;
    t_layout();
    t_irq();
    t_laser();
    t_access();
    t_reset();
    results();
  end
endmodule // tb_top
